/* design/smbus_consts.svh */
// Purpose: Shared constants for the two-wire power-controller port.
// Assumes: Reference clock of 4 ns; bus clock made by the host divider.
// Notes:   Addresses are seven bits, transmitted most significant first.
`ifndef SMBUS_CONSTS_SVH
`define SMBUS_CONSTS_SVH

// Upper three bits of the strap-selected primary address.
`define PRIMARY_ADDR_HI 3'h2
// Address that every device accepts for writes.
`define BROADCAST_ADDR 7'h30
// Address a device answers only while its interrupt is pending.
`define ALERT_RESP_ADDR 7'h0C
// Width of the internal register pointer.
`define PTR_WIDTH 5
// Pointer value of the interrupt register.
`define INT_REG_PTR 5'h00

// Reference clock period and the bus clock period the host makes.
`define REF_PERIOD_NS 4
`define SCL_PERIOD_NS 160
// Reference cycles per quarter of a bus clock period.
`define QUARTER_CYC (`SCL_PERIOD_NS / (4 * `REF_PERIOD_NS))
`define DIV_WIDTH 10

`endif

/* design/smbus_pkg.sv */
// Purpose: Types shared by both ends of the two-wire port.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package smbus_pkg;

	// Device receive and transmit phases.
	typedef enum logic [6:0] {
		ST_ADDR = 7'h01,
		ST_ACK = 7'h02,
		ST_CMD = 7'h04,
		ST_DATA = 7'h08,
		ST_SEND = 7'h10,
		ST_MACK = 7'h20,
		ST_IGNORE = 7'h40
	} dev_state_e;

	// Host sequencer states.
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BYTE = 4'h4,
		H_STOP = 4'h8
	} host_state_e;

	// Transfer kinds that the host may issue.
	typedef enum logic [1:0] {
		K_WRITE = 2'h0,
		K_READ = 2'h1,
		K_RECV = 2'h2,
		K_ARA = 2'h3
	} cmd_kind_e;

	// Segments of a transfer.
	typedef enum logic [1:0] {
		SEG_START = 2'h0,
		SEG_WR = 2'h1,
		SEG_RD = 2'h2,
		SEG_STOP = 2'h3
	} seg_e;

endpackage

/* design/smbus_if.sv */
// Purpose: Carrier joining the host end and the device end of the bus.
// Assumes: Open-drain data line with a pull-up; clock driven by the host.
// Notes:   The device's separate receive and transmit pins are tied here.
`timescale 1ns/1ps
`default_nettype none
interface smbus_if;
	logic scl;
	logic hostSdaOut;
	logic hostSdaOe;
	logic serialDataOut;
	logic serialDataIn;
	logic sdaLine;

	// Wired-AND of both drivers; a released line reads high.
	assign sdaLine = (hostSdaOe ? hostSdaOut : 1'b1) & serialDataOut;
	assign serialDataIn = sdaLine;

	modport device (
		input scl,
		input serialDataIn,
		output serialDataOut
	);

	modport host (
		output scl,
		output hostSdaOut,
		output hostSdaOe,
		input sdaLine
	);
endinterface
`default_nettype wire

/* design/pse_smbus_slave_port.sv */
// Purpose: Slave end of the two-wire port of a four-port power controller.
// Assumes: Bus clock runs only during transfers; rst is from ref_clk side.
// Notes:   Link logic runs on the bus clock; the interrupt pin on ref_clk.
//
// Overview of operation
// (R1) Master leaves both lines high when idle.
// (R2) Data falling while clock high starts transfer.
// (R3) Data rising while clock high stops transfer.
// (R4) Repeated start behaves exactly like start.
// (R5) Answer primary address 010 plus straps.
// (R6) Accept writes to broadcast address 0110000.
// (R7) Answer alert address only while interrupt low.
// (R8) Only write, read and receive byte used.
// (R9) Interrupt pin changes only between transactions.
// (R10) Data pin split into input and output.
// (R11) Raise interrupt after internal reset.
// (R12) Keep low five command bits; stop clears.
// (R13) Receive byte returns interrupt register.
// (R14) Alert reply arbitrates; success releases interrupt.
// (R15) Ignore every other address.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_consts.svh"
module pse_smbus_slave_port
	import smbus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] addrStrapPins,
	input wire logic intEvent,
	input wire logic intClear,
	input wire logic [7:0] intStatus,
	output logic wrStrobe,
	output logic [4:0] wrAddr,
	output logic [7:0] wrData,
	output logic intN,
	smbus_if.device bus
);

	// ********************************************************************
	// Start and stop detection
	// ********************************************************************

	logic startTgl_q;
	logic startTgl_d;
	logic stopTgl_q;
	logic stopTgl_d;

	// Each condition flips a toggle on the data edge itself, since the bus
	// clock is high and still while it happens.
	always_comb begin
		startTgl_d = bus.scl ? ~startTgl_q : startTgl_q; // [R2] [R4]
		stopTgl_d = bus.scl ? ~stopTgl_q : stopTgl_q; // [R3]
	end

	// Reset is taken asynchronously because the bus clock may be still.
	always_ff @(negedge bus.serialDataIn or posedge rst) begin
		if (rst) begin
			startTgl_q <= 1'b0;
		end else begin
			startTgl_q <= startTgl_d;
		end
	end

	// Stop toggle register.
	always_ff @(posedge bus.serialDataIn or posedge rst) begin
		if (rst) begin
			stopTgl_q <= 1'b0;
		end else begin
			stopTgl_q <= stopTgl_d;
		end
	end

	// ********************************************************************
	// Bus clock domain: byte engine
	// ********************************************************************

	dev_state_e state_q;
	dev_state_e state_d;
	dev_state_e next_q;
	dev_state_e next_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic [4:0] ptr_q;
	logic [4:0] ptr_d;
	logic ara_q;
	logic ara_d;
	logic startSeen_q;
	logic stopSeen_q;
	logic wrTgl_q;
	logic wrTgl_d;
	logic [4:0] wrAddrL_q;
	logic [4:0] wrAddrL_d;
	logic [7:0] wrDataL_q;
	logic [7:0] wrDataL_d;
	logic araTgl_q;
	logic araTgl_d;
	logic [3:0] strapS1_q;
	logic [3:0] strapS2_q;
	logic pendS1_q;
	logic pendS2_q;
	logic memWe;
	logic newStart;
	logic newStop;
	logic bitIn;
	logic [6:0] ownAddr;
	logic [7:0] readByte;
	logic [7:0] regMem [0:31];
	logic [7:0] snap_q;

	// Next values of the byte engine. The toggles are read with one flop
	// because the bus guarantees a setup time between a condition and the
	// next rising clock edge; the snapshot is frozen while busy.
	always_comb begin
		newStart = startTgl_q != startSeen_q;
		newStop = stopTgl_q != stopSeen_q;
		bitIn = bus.serialDataIn; // [R10]
		ownAddr = {`PRIMARY_ADDR_HI, strapS2_q};
		readByte = (ptr_q == `INT_REG_PTR) ? snap_q : regMem[ptr_q]; // [R13]
		state_d = state_q;
		next_d = next_q;
		cnt_d = cnt_q + 4'd1;
		sh_d = {sh_q[6:0], bitIn};
		tx_d = tx_q;
		ptr_d = newStop ? `INT_REG_PTR : ptr_q; // [R12]
		ara_d = ara_q;
		wrTgl_d = wrTgl_q;
		wrAddrL_d = wrAddrL_q;
		wrDataL_d = wrDataL_q;
		araTgl_d = araTgl_q;
		memWe = 1'b0;
		if (newStart) begin
			state_d = ST_ADDR; // [R2] [R4]
			cnt_d = 4'd1;
			sh_d = {7'h00, bitIn};
			ara_d = 1'b0;
		end else begin
			case (state_q)
				ST_ADDR: begin
					if (cnt_q == 4'd7) begin
						state_d = ST_IGNORE; // [R15]
						cnt_d = 4'd0;
						if (sh_q[6:0] == ownAddr) begin
							state_d = ST_ACK; // [R5]
							next_d = bitIn ? ST_SEND : ST_CMD; // [R8]
							tx_d = readByte;
						end else if (sh_q[6:0] == `BROADCAST_ADDR && !bitIn) begin
							state_d = ST_ACK; // [R6]
							next_d = ST_CMD;
						end else if (sh_q[6:0] == `ALERT_RESP_ADDR && bitIn
							&& pendS2_q) begin
							state_d = ST_ACK; // [R7]
							next_d = ST_SEND;
							tx_d = {ownAddr, 1'b1}; // [R14]
							ara_d = 1'b1;
						end
					end
				end
				ST_ACK: begin
					state_d = next_q;
					cnt_d = 4'd0;
				end
				ST_CMD: begin
					if (cnt_q == 4'd7) begin
						ptr_d = sh_d[4:0]; // [R12]
						state_d = ST_ACK;
						next_d = ST_DATA;
						cnt_d = 4'd0;
					end
				end
				ST_DATA: begin
					if (cnt_q == 4'd7) begin
						memWe = 1'b1;
						wrAddrL_d = ptr_q;
						wrDataL_d = sh_d;
						wrTgl_d = ~wrTgl_q;
						state_d = ST_ACK;
						next_d = ST_IGNORE; // [R8]
						cnt_d = 4'd0;
					end
				end
				ST_SEND: begin
					tx_d = {tx_q[6:0], 1'b1};
					if (ara_q && tx_q[7] && !bitIn) begin
						state_d = ST_IGNORE; // [R14]
						ara_d = 1'b0;
					end else if (cnt_q == 4'd7) begin
						if (ara_q) begin
							araTgl_d = ~araTgl_q; // [R14]
						end
						state_d = ST_MACK;
						cnt_d = 4'd0;
					end
				end
				ST_MACK: begin
					cnt_d = 4'd0;
					if (!bitIn && !ara_q) begin
						state_d = ST_SEND;
						tx_d = readByte;
					end else begin
						state_d = ST_IGNORE;
					end
				end
				default: begin
					state_d = ST_IGNORE;
				end
			endcase
		end
	end

	// Byte engine registers, sampled on the rising bus clock edge.
	always_ff @(posedge bus.scl or posedge rst) begin
		if (rst) begin
			state_q <= ST_IGNORE;
			next_q <= ST_IGNORE;
			cnt_q <= 4'd0;
			sh_q <= 8'h00;
			tx_q <= 8'hFF;
			ptr_q <= `INT_REG_PTR;
			ara_q <= 1'b0;
			startSeen_q <= 1'b0;
			stopSeen_q <= 1'b0;
			wrTgl_q <= 1'b0;
			wrAddrL_q <= 5'h00;
			wrDataL_q <= 8'h00;
			araTgl_q <= 1'b0;
			strapS1_q <= 4'h0;
			strapS2_q <= 4'h0;
			pendS1_q <= 1'b0;
			pendS2_q <= 1'b0;
		end else begin
			state_q <= state_d;
			next_q <= next_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			ara_q <= ara_d;
			startSeen_q <= startTgl_q;
			stopSeen_q <= stopTgl_q;
			wrTgl_q <= wrTgl_d;
			wrAddrL_q <= wrAddrL_d;
			wrDataL_q <= wrDataL_d;
			araTgl_q <= araTgl_d;
			strapS1_q <= addrStrapPins;
			strapS2_q <= strapS1_q;
			pendS1_q <= ~intN;
			pendS2_q <= pendS1_q;
		end
	end

	// Register storage for control bytes written by the host.
	always_ff @(posedge bus.scl) begin
		if (memWe) begin
			regMem[ptr_q] <= sh_d;
		end
	end

	// ********************************************************************
	// Bus clock domain: data output on the falling edge
	// ********************************************************************

	logic serial_data_out_q;
	logic serial_data_out_d;

	// Drive low for acknowledge, shift out on send, release otherwise.
	always_comb begin
		serial_data_out_d = 1'b1;
		if (state_q == ST_ACK) begin
			serial_data_out_d = 1'b0;
		end else if (state_q == ST_SEND) begin
			serial_data_out_d = tx_q[7];
		end
	end

	// Changing data only while the clock is low keeps it stable when high.
	always_ff @(negedge bus.scl or posedge rst) begin
		if (rst) begin
			serial_data_out_q <= 1'b1;
		end else begin
			serial_data_out_q <= serial_data_out_d;
		end
	end

	assign bus.serialDataOut = serial_data_out_q; // [R10]

	// ********************************************************************
	// Reference clock domain: interrupt pin and write hand-off
	// ********************************************************************

	logic [2:0] stS_q;
	logic [2:0] spS_q;
	logic [2:0] wrS_q;
	logic [2:0] araS_q;
	logic pend_q;
	logic pend_d;
	logic intN_q;
	logic intN_d;
	logic [7:0] snap_d;
	logic wrStrobe_q;
	logic wrStrobe_d;
	logic [4:0] wrAddr_q;
	logic [4:0] wrAddr_d;
	logic [7:0] wrData_q;
	logic [7:0] wrData_d;
	logic busy;
	logic busy_q;
	logic busy_d;
	logic araDone;

	// Interrupt and write hand-off. A set request wins over a clear, so an
	// event in the clearing cycle is not lost.
	always_comb begin
		// A repeated start flips the start toggle once more, so the two
		// toggles are not compared; an edge of either sets or clears busy.
		busy_d = busy_q;
		if (spS_q[2] != spS_q[1]) begin
			busy_d = 1'b0; // [R3]
		end
		if (stS_q[2] != stS_q[1]) begin
			busy_d = 1'b1; // [R4]
		end
		busy = busy_d;
		araDone = araS_q[2] ^ araS_q[1];
		pend_d = pend_q;
		if (araDone || intClear) begin
			pend_d = 1'b0; // [R14]
		end
		if (intEvent) begin
			pend_d = 1'b1;
		end
		intN_d = busy ? intN_q : ~pend_q; // [R9]
		snap_d = busy ? snap_q : intStatus;
		wrStrobe_d = wrS_q[2] ^ wrS_q[1];
		wrAddr_d = wrStrobe_d ? wrAddrL_q : wrAddr_q;
		wrData_d = wrStrobe_d ? wrDataL_q : wrData_q;
	end

	// Pending starts set so the host learns of the reset.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stS_q <= 3'h0;
			spS_q <= 3'h0;
			busy_q <= 1'b0;
			wrS_q <= 3'h0;
			araS_q <= 3'h0;
			pend_q <= 1'b1; // [R11]
			intN_q <= 1'b1;
			snap_q <= 8'h00;
			wrStrobe_q <= 1'b0;
			wrAddr_q <= 5'h00;
			wrData_q <= 8'h00;
		end else begin
			stS_q <= {stS_q[1:0], startTgl_q};
			spS_q <= {spS_q[1:0], stopTgl_q};
			busy_q <= busy_d;
			wrS_q <= {wrS_q[1:0], wrTgl_q};
			araS_q <= {araS_q[1:0], araTgl_q};
			pend_q <= pend_d;
			intN_q <= intN_d;
			snap_q <= snap_d;
			wrStrobe_q <= wrStrobe_d;
			wrAddr_q <= wrAddr_d;
			wrData_q <= wrData_d;
		end
	end

	assign intN = intN_q;
	assign wrStrobe = wrStrobe_q;
	assign wrAddr = wrAddr_q;
	assign wrData = wrData_q;

endmodule // pse_smbus_slave_port
`default_nettype wire

/* design/smbus_host_port.sv */
// Purpose: Bus master end that issues single transfers to the controller.
// Assumes: One command at a time; bus clock divided from ref_clk.
// Notes:   Only write, read, receive and alert-response transfers exist.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_consts.svh"
module smbus_host_port
	import smbus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire cmd_kind_e cmdKind,
	input wire logic [6:0] cmdAddr,
	input wire logic [7:0] cmdReg,
	input wire logic [7:0] cmdData,
	output logic respValid,
	output logic respAck,
	output logic [7:0] respData,
	smbus_if.host bus
);

	// ********************************************************************
	// Sequencer
	// ********************************************************************

	host_state_e st_q;
	host_state_e st_d;
	cmd_kind_e kind_q;
	cmd_kind_e kind_d;
	logic [`DIV_WIDTH-1:0] div_q;
	logic [`DIV_WIDTH-1:0] div_d;
	logic [1:0] qtr_q;
	logic [1:0] qtr_d;
	logic [2:0] seg_q;
	logic [2:0] seg_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [6:0] addr_q;
	logic [6:0] addr_d;
	logic [7:0] reg_q;
	logic [7:0] reg_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic isRd_q;
	logic isRd_d;
	logic ack_q;
	logic ack_d;
	logic scl_q;
	logic scl_d;
	logic oe_q;
	logic oe_d;
	logic [1:0] sdaS_q;
	logic rdy_q;
	logic rdy_d;
	logic rv_q;
	logic rv_d;
	logic tick;
	logic [2:0] nSeg;
	seg_e plan;
	logic [7:0] planByte;

	// Segment plan; reads use a repeated start, never a stop, to turn.
	always_comb begin
		nSeg = seg_q + 3'd1;
		plan = SEG_STOP;
		planByte = {addr_q, 1'b1};
		case (kind_q)
			K_WRITE: begin
				case (nSeg)
					3'd1: begin plan = SEG_WR; planByte = {addr_q, 1'b0}; end
					3'd2: begin plan = SEG_WR; planByte = reg_q; end
					3'd3: begin plan = SEG_WR; planByte = data_q; end
					default: plan = SEG_STOP;
				endcase
			end
			K_READ: begin
				case (nSeg)
					3'd1: begin plan = SEG_WR; planByte = {addr_q, 1'b0}; end
					3'd2: begin plan = SEG_WR; planByte = reg_q; end
					3'd3: plan = SEG_START; // [R4]
					3'd4: plan = SEG_WR;
					3'd5: plan = SEG_RD;
					default: plan = SEG_STOP;
				endcase
			end
			default: begin
				case (nSeg)
					3'd1: plan = SEG_WR; // [R8]
					3'd2: plan = SEG_RD;
					default: plan = SEG_STOP;
				endcase
			end
		endcase
	end

	// Quarter-period steps: set data, raise clock, sample, lower clock.
	always_comb begin
		tick = div_q == `DIV_WIDTH'(`QUARTER_CYC - 1);
		div_d = tick ? '0 : div_q + `DIV_WIDTH'(1);
		st_d = st_q;
		kind_d = kind_q;
		qtr_d = qtr_q;
		seg_d = seg_q;
		bit_d = bit_q;
		sh_d = sh_q;
		addr_d = addr_q;
		reg_d = reg_q;
		data_d = data_q;
		isRd_d = isRd_q;
		ack_d = ack_q;
		scl_d = scl_q;
		oe_d = oe_q;
		rdy_d = rdy_q;
		rv_d = 1'b0;
		case (st_q)
			H_IDLE: begin
				scl_d = 1'b1; // [R1]
				oe_d = 1'b0;
				div_d = '0;
				if (cmdValid && rdy_q) begin
					rdy_d = 1'b0;
					st_d = H_START;
					kind_d = cmdKind;
					addr_d = (cmdKind == K_ARA) ? `ALERT_RESP_ADDR : cmdAddr;
					reg_d = cmdReg;
					data_d = cmdData;
					seg_d = 3'd0;
					qtr_d = 2'd0;
					ack_d = 1'b1;
				end
			end
			default: begin
				if (tick) begin
					qtr_d = qtr_q + 2'd1;
					case (qtr_q)
						2'd0: begin
							if (st_q == H_BYTE) begin
								oe_d = !isRd_q && bit_q < 4'd8 && !sh_q[7];
							end else begin
								oe_d = st_q == H_STOP;
							end
						end
						2'd1: scl_d = 1'b1;
						2'd2: begin
							if (st_q == H_START) begin
								oe_d = 1'b1; // [R2]
							end else if (st_q == H_STOP) begin
								oe_d = 1'b0; // [R3]
							end else if (bit_q < 4'd8) begin
								sh_d = {sh_q[6:0], sdaS_q[1]};
							end else if (!isRd_q && sdaS_q[1]) begin
								ack_d = 1'b0;
							end
						end
						default: begin
							scl_d = st_q == H_STOP;
							bit_d = bit_q + 4'd1;
							if (st_q == H_STOP) begin
								st_d = H_IDLE;
								rdy_d = 1'b1;
								rv_d = 1'b1;
							end else if (st_q == H_START || bit_q == 4'd8) begin
								seg_d = nSeg;
								bit_d = 4'd0;
								isRd_d = plan == SEG_RD;
								if (!ack_d || plan == SEG_STOP) begin
									st_d = H_STOP;
								end else if (plan == SEG_START) begin
									st_d = H_START;
								end else begin
									st_d = H_BYTE;
									if (plan == SEG_WR) begin
										sh_d = planByte;
									end
								end
							end
						end
					endcase
				end
			end
		endcase
	end

	// Sequencer registers; the line input passes two flops first.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= H_IDLE;
			kind_q <= K_WRITE;
			div_q <= '0;
			qtr_q <= 2'd0;
			seg_q <= 3'd0;
			bit_q <= 4'd0;
			sh_q <= 8'h00;
			addr_q <= 7'h00;
			reg_q <= 8'h00;
			data_q <= 8'h00;
			isRd_q <= 1'b0;
			ack_q <= 1'b0;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			sdaS_q <= 2'h3;
			rdy_q <= 1'b1;
			rv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			div_q <= div_d;
			qtr_q <= qtr_d;
			seg_q <= seg_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			reg_q <= reg_d;
			data_q <= data_d;
			isRd_q <= isRd_d;
			ack_q <= ack_d;
			scl_q <= scl_d;
			oe_q <= oe_d;
			sdaS_q <= {sdaS_q[0], bus.sdaLine};
			rdy_q <= rdy_d;
			rv_q <= rv_d;
		end
	end

	assign bus.scl = scl_q;
	assign bus.hostSdaOe = oe_q;
	assign bus.hostSdaOut = 1'b0;
	assign cmdReady = rdy_q;
	assign respValid = rv_q;
	assign respAck = ack_q;
	assign respData = sh_q;

endmodule // smbus_host_port
`default_nettype wire

/* bench/pse_smbus_slave_port_asserts.sv */
// Purpose: Wire-level checks on the bus between host end and device end.
// Assumes: Sampled on ref_clk; the bus clock is slow next to it.
// Notes:   Start and stop are found from two samples of the lines.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_consts.svh"
module pse_smbus_slave_port_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic serialDataOut,
	input wire logic serialDataIn,
	input wire logic sdaLine,
	input wire logic intN
);
	// Start leads to a falling bus clock within one quarter plus slack.
	localparam int QCM = `QUARTER_CYC + 8;
	logic sclQ, sdaQ, busyQ, busyD, startEv, stopEv;
	logic [7:0] busyCntQ, busyCntD;

	// Bus state tracking; the count lets the interrupt settle after start.
	always_comb begin
		startEv = sclQ && scl && sdaQ && !serialDataIn;
		stopEv = sclQ && scl && !sdaQ && serialDataIn;
		busyD = startEv || (busyQ && !stopEv);
		busyCntD = !busyD ? 8'h00 : busyCntQ + 8'(busyCntQ != 8'hff);
	end

	// Registers of the tracking logic.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			busyQ <= 1'b0;
			busyCntQ <= 8'h00;
		end else begin
			sclQ <= scl;
			sdaQ <= serialDataIn;
			busyQ <= busyD;
			busyCntQ <= busyCntD;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence startSeq;
		startEv;
	endsequence
	sequence stopSeq;
		stopEv;
	endsequence
	sequence busFree;
		scl && sdaLine;
	endsequence

	idle_lines_a: assert property (!busyQ && !startEv |-> busFree)
		else $error("bus lines not high while idle");
	dev_release_a: assert property (!busyQ |-> serialDataOut)
		else $error("device pulls data while bus idle");
	// While the host holds data low with the clock high, the device is off.
	open_drain_a: assert property (scl && hostSdaOe
		&& !hostSdaOut |-> serialDataOut)
		else $error("device pulls data against the host");
	start_clock_a: assert property (startSeq |-> ##[1:QCM] !scl)
		else $error("no clock low after start");
	stop_free_a: assert property (stopSeq |=> busFree [*8])
		else $error("bus not free after stop");
	dev_bit_a: assert property (scl && sclQ |-> $stable(serialDataOut))
		else $error("device data moved while clock high");
	host_bit_a: assert property (scl && sclQ && $changed(hostSdaOe) |->
		startEv || stopEv)
		else $error("host data moved while clock high");
	int_quiet_a: assert property (busyCntQ > 8'd8 |-> $stable(intN))
		else $error("interrupt moved inside a transfer");
	int_reset_a: assert property ($fell(rst) |-> ##[1:6] !intN)
		else $error("no interrupt after reset");
	rep_start_c: cover property (busyQ && startEv);
endmodule // pse_smbus_slave_port_asserts
`default_nettype wire

/* bench/pse_smbus_slave_port_test.sv */
// Purpose: Issues host transfers to the device end and scores results.
// Assumes: The host divides the bus clock; a transfer is long.
// Notes:   Expected results wait in queues until the outputs appear.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_consts.svh"
module pse_smbus_slave_port_test
	import smbus_pkg::*;
();
	// Ceiling for one transfer, in reference cycles.
	localparam int XFER_CYC = 200 * `QUARTER_CYC;
	logic ref_clk, rst, cmdValid, cmdReady, respValid, respAck;
	logic wrStrobe, intN, intEvent, intClear;
	cmd_kind_e cmdKind;
	logic [6:0] cmdAddr;
	logic [7:0] cmdReg, cmdData, respData, wrData, intStatus;
	logic [4:0] wrAddr;
	logic [3:0] strap;
	logic [9:0] respQ[$];
	logic [12:0] wrQ[$];
	int n_errors, n_checks, cycles;

	smbus_if bus();
	smbus_host_port u_smbus_host_port (.ref_clk(ref_clk), .rst(rst),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
		.cmdAddr(cmdAddr), .cmdReg(cmdReg), .cmdData(cmdData),
		.respValid(respValid), .respAck(respAck), .respData(respData),
		.bus(bus));
	pse_smbus_slave_port u_pse_smbus_slave_port (.ref_clk(ref_clk),
		.rst(rst), .addrStrapPins(strap), .intEvent(intEvent),
		.intClear(intClear), .intStatus(intStatus), .wrStrobe(wrStrobe),
		.wrAddr(wrAddr), .wrData(wrData), .intN(intN), .bus(bus));
	pse_smbus_slave_port_asserts u_pse_smbus_slave_port_asserts (
		.ref_clk(ref_clk), .rst(rst), .scl(bus.scl),
		.hostSdaOut(bus.hostSdaOut), .hostSdaOe(bus.hostSdaOe),
		.serialDataOut(bus.serialDataOut), .serialDataIn(bus.serialDataIn),
		.sdaLine(bus.sdaLine), .intN(intN));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Holds the request one edge, then waits for the response pulse.
	task automatic doCmd(input cmd_kind_e k, input logic [6:0] a,
		input logic [7:0] r, input logic [7:0] d, input logic eAck,
		input logic [7:0] eData, input logic chk);
		int n;
		respQ.push_back({chk, eAck, eData});
		@(posedge ref_clk);
		cmdValid <= 1'b1;
		cmdKind <= k;
		cmdAddr <= a;
		cmdReg <= r;
		cmdData <= d;
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		@(posedge ref_clk);
		check("cmdReady", cmdReady, 1'b0);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (respValid !== 1'b1 && n < XFER_CYC);
	endtask

	// The pin follows the sync stages, so allow a short bounded wait.
	task automatic waitInt(input logic v);
		int n;
		n = 0;
		while (intN !== v && n < 64) begin
			@(posedge ref_clk);
			n++;
		end
		check("intN", intN, v);
	endtask

	// ****************************************
	// Clock, monitors and timeout
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Each result pulse is scored against the oldest note.
	always @(posedge ref_clk) begin
		logic [9:0] e;
		logic [12:0] w;
		if (respValid === 1'b1) begin
			check("respQ", respQ.size() > 0, 1'b1);
			e = respQ.pop_front();
			check("respAck", respAck, e[8]);
			if (e[9]) check("respData", respData, e[7:0]);
		end
		if (wrStrobe === 1'b1) begin
			check("wrQ", wrQ.size() > 0, 1'b1);
			w = wrQ.pop_front();
			check("wrAddr", wrAddr, w[12:8]);
			check("wrData", wrData, w[7:0]);
		end
	end

	// A hang is counted as a mismatch and closes the run.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles >= 9 * XFER_CYC) begin
			n_errors++;
			stop_test();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] ptr, d1, d2;
		logic [6:0] prim;
		void'($urandom(32'h7d60));
		rst = 1'b1;
		cmdValid = 1'b0;
		cmdKind = K_WRITE;
		cmdAddr = 7'h00;
		cmdReg = 8'h00;
		cmdData = 8'h00;
		intEvent = 1'b0;
		intClear = 1'b0;
		intStatus = 8'h00;
		strap = 4'($urandom);
		prim = {`PRIMARY_ADDR_HI, strap};
		ptr = {3'b111, 5'($urandom % 31 + 1)};
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		waitInt(1'b0);
		$display("test reset done");
		wrQ.push_back({ptr[4:0], d1});
		doCmd(K_WRITE, prim, ptr, d1, 1'b1, 8'h00, 1'b0);
		doCmd(K_READ, prim, ptr ^ 8'he0, 8'h00, 1'b1, d1, 1'b1);
		$display("test write read done");
		intStatus <= d2;
		doCmd(K_RECV, prim, 8'h00, 8'h00, 1'b1, d2, 1'b1);
		$display("test receive done");
		wrQ.push_back({5'(ptr + 8'h01), d2});
		doCmd(K_WRITE, `BROADCAST_ADDR, ptr + 8'h01, d2, 1'b1, 8'h00,
			1'b0);
		doCmd(K_WRITE, {`PRIMARY_ADDR_HI, ~strap}, ptr, d1, 1'b0, 8'h00,
			1'b0);
		$display("test addresses done");
		doCmd(K_ARA, `ALERT_RESP_ADDR, 8'h00, 8'h00, 1'b1, {prim, 1'b1},
			1'b1);
		waitInt(1'b1);
		doCmd(K_ARA, `ALERT_RESP_ADDR, 8'h00, 8'h00, 1'b0, 8'h00,
			1'b0);
		$display("test alert done");
		// An event raised inside a read, after its repeated start, must
		// not reach the pin before the stop.
		fork
			doCmd(K_READ, prim, ptr, 8'h00, 1'b1, d1, 1'b1);
			begin
				repeat (900) @(posedge ref_clk);
				intEvent <= 1'b1;
				repeat (4) @(posedge ref_clk);
				intEvent <= 1'b0;
				check("intHeld", intN, 1'b1);
			end
		join
		waitInt(1'b0);
		intClear <= 1'b1;
		@(posedge ref_clk);
		intClear <= 1'b0;
		waitInt(1'b1);
		$display("test interrupt done");
		check("respLeft", 16'(respQ.size()), 16'h0000);
		check("wrLeft", 16'(wrQ.size()), 16'h0000);
		stop_test();
	end
endmodule // pse_smbus_slave_port_test
`default_nettype wire
